// ---- rtl/nsp_pkg.sv ----
/*
 nsp_pkg: constants, types and register map of the negate / stack-pop executor.
 assumes: single clock clk_sys, apb slave with 32-bit data, word-aligned offsets.
*/
package nsp_pkg;

  // opcode patterns
  localparam logic [6:0]  NEG_OPC       = 7'h36;
  localparam logic [15:0] POP_OPC       = 16'h0006;
  localparam int          NEG_OPC_LSB   = 9;
  localparam int          BANK_BIT      = 8;

  // status flag positions
  localparam int          FLG_C         = 0;
  localparam int          FLG_DC        = 1;
  localparam int          FLG_Z         = 2;
  localparam int          FLG_OV        = 3;
  localparam int          FLG_N         = 4;

  localparam int          STACK_DEPTH   = 31;
  localparam int          SP_W          = 5;
  localparam int          PC_W          = 21;
  localparam int          BANKS         = 16;

  // register byte offsets
  localparam logic [7:0]  OFS_INSTR     = 8'h00;
  localparam logic [7:0]  OFS_BANK_SEL  = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_TOP       = 8'h0c;
  localparam logic [7:0]  OFS_PUSH      = 8'h10;
  localparam logic [7:0]  OFS_MEM_ADDR  = 8'h14;
  localparam logic [7:0]  OFS_MEM_DATA  = 8'h18;
  localparam logic [7:0]  OFS_DEPTH     = 8'h1c;

  localparam logic [7:0]  BANK_SEL_RST  = 8'h00;
  localparam logic [4:0]  STATUS_RST    = 5'h00;

  // access bank: low half maps to bank 0, high half to bank 15
  localparam logic [7:0]  ACC_SPLIT     = 8'h80;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hf;

  typedef enum logic [2:0]
  {
    NSP_IDLE = 3'b000,
    NSP_Q1   = 3'b001,
    NSP_Q2   = 3'b010,
    NSP_Q3   = 3'b011,
    NSP_Q4   = 3'b100
  } nsp_phase_t;

  typedef struct packed
  {
    logic       neg;
    logic       pop;
    logic       bank_a;
    logic [7:0] faddr;
  } nsp_dec_t;

  typedef struct packed
  {
    logic [7:0] res;
    logic [4:0] flags;
  } nsp_alu_t;

endpackage : nsp_pkg

// ---- rtl/nsp_neg_alu.sv ----
/*
 nsp_neg_alu: combinational two's complement negate with status flags.
 assumes: operand held stable by the caller for the phase it is sampled in.
*/
`timescale 1ns/1ps
module nsp_neg_alu
(
  input  wire logic [7:0]       opnd,
  output nsp_pkg::nsp_alu_t     out
);

  logic [8:0] sum;
  logic [4:0] low;

  always_comb
  begin
    sum   = {1'b0, ~opnd} + 9'h001;
    low   = {1'b0, ~opnd[3:0]} + 5'h01;
    out.res = sum[7:0];
    out.flags = '0;
    out.flags[nsp_pkg::FLG_C]  = sum[8];
    out.flags[nsp_pkg::FLG_DC] = low[4];
    out.flags[nsp_pkg::FLG_Z]  = (sum[7:0] == 8'h00);
    // only 0x80 negates to itself with the sign bit set
    out.flags[nsp_pkg::FLG_OV] = opnd[7] & sum[7];
    out.flags[nsp_pkg::FLG_N]  = sum[7];
  end

endmodule : nsp_neg_alu

// ---- rtl/nsp_exec.sv ----
/*
 nsp_exec: executes negate-file and pop-stack instructions, apb slave.
 assumes: apb master keeps the request stable until pready; one clock.
*/
// The APB register port and the register addresses were left to the implementer.
// Behaviour
// - negate writes invert plus one
// - result returns to the same file address
// - decode negate by opcode 0110 110
// - negate sets n, ov, c, dc, z
// - bank bit 0 access bank, 1 bank register
// - pop discards top, pc untouched
// - after pop, previous entry is top
`timescale 1ns/1ps
module nsp_exec
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int MEM_N = nsp_pkg::BANKS * 256;

  logic [7:0]              dmem_r [MEM_N];
  logic [nsp_pkg::PC_W-1:0] stk_r [nsp_pkg::STACK_DEPTH];
  logic [nsp_pkg::SP_W-1:0] sp_r, sp_nxt;
  logic [15:0]             ir_r, ir_nxt;
  logic [7:0]              bank_select_reg_r, bank_select_reg_nxt;
  logic [4:0]              status_r, status_nxt;
  logic [11:0]             ea_r, ea_nxt, maddr_r, maddr_nxt;
  logic [7:0]              opnd_r, opnd_nxt;
  nsp_pkg::nsp_phase_t     ph_r, ph_nxt;
  nsp_pkg::nsp_dec_t       dec;
  nsp_pkg::nsp_alu_t       alu;
  logic [31:0]             prdata_nxt;
  logic                    pready_nxt, pslverr_nxt;
  logic                    acc, wr_en, rd_en;
  logic                    mem_we, push_we;
  logic [11:0]             mem_wa;
  logic [7:0]              mem_wd;

  nsp_neg_alu u_alu
  (
    .opnd (opnd_r),
    .out  (alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb
  begin
    dec.neg    = (ir_r[15:nsp_pkg::NEG_OPC_LSB] == nsp_pkg::NEG_OPC);
    dec.pop    = (ir_r == nsp_pkg::POP_OPC);
    dec.bank_a = ir_r[nsp_pkg::BANK_BIT];
    dec.faddr  = ir_r[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode and instruction sequencer
  always_comb
  begin
    acc                 = psel & penable & ~pready;
    wr_en               = acc & pwrite;
    rd_en               = acc & ~pwrite;
    ir_nxt              = ir_r;
    bank_select_reg_nxt = bank_select_reg_r;
    status_nxt          = status_r;
    ea_nxt              = ea_r;
    opnd_nxt            = opnd_r;
    maddr_nxt           = maddr_r;
    sp_nxt              = sp_r;
    ph_nxt              = ph_r;
    mem_we              = 1'b0;
    mem_wa              = maddr_r;
    mem_wd              = pwdata[7:0];
    push_we             = 1'b0;
    prdata_nxt          = 32'h0000_0000;
    pslverr_nxt         = 1'b0;
    pready_nxt          = acc;
    // writes to instr wait while a cycle runs; reads answer at once
    if (wr_en && paddr == nsp_pkg::OFS_INSTR && ph_r != nsp_pkg::NSP_IDLE)
    begin
      pready_nxt = 1'b0;
    end
    case (ph_r)
      nsp_pkg::NSP_Q1:
      begin
        if (!dec.bank_a)
        begin
          ea_nxt = {(dec.faddr >= nsp_pkg::ACC_SPLIT) ? nsp_pkg::ACC_HI_BANK : 4'h0,
                    dec.faddr};
        end
        else
        begin
          ea_nxt = {bank_select_reg_r[3:0], dec.faddr};
        end
        ph_nxt = nsp_pkg::NSP_Q2;
      end
      nsp_pkg::NSP_Q2:
      begin
        opnd_nxt = dmem_r[ea_r];
        ph_nxt   = nsp_pkg::NSP_Q3;
      end
      nsp_pkg::NSP_Q3:
      begin
        if (dec.pop && sp_r != '0)
        begin
          sp_nxt = sp_r - 5'd1;
        end
        ph_nxt = nsp_pkg::NSP_Q4;
      end
      nsp_pkg::NSP_Q4:
      begin
        if (dec.neg)
        begin
          mem_we     = 1'b1;
          mem_wa     = ea_r;
          mem_wd     = alu.res;
          status_nxt = alu.flags;
        end
        ph_nxt = nsp_pkg::NSP_IDLE;
      end
      default:
      begin
        ph_nxt = nsp_pkg::NSP_IDLE;
      end
    endcase
    if (wr_en && pready_nxt)
    begin
      case (paddr)
        nsp_pkg::OFS_INSTR:
        begin
          ir_nxt = pwdata[15:0];
          ph_nxt = nsp_pkg::NSP_Q1;
        end
        nsp_pkg::OFS_BANK_SEL: bank_select_reg_nxt = pwdata[7:0];
        nsp_pkg::OFS_STATUS:
        begin
          // flag update of a finishing negate beats a software write
          if (!(ph_r == nsp_pkg::NSP_Q4 && dec.neg))
          begin
            status_nxt = pwdata[4:0];
          end
        end
        nsp_pkg::OFS_PUSH:
        begin
          if (sp_r < 5'(nsp_pkg::STACK_DEPTH))
          begin
            push_we = 1'b1;
            sp_nxt  = sp_r + 5'd1;
          end
          else
          begin
            pslverr_nxt = 1'b1;
          end
        end
        nsp_pkg::OFS_MEM_ADDR: maddr_nxt = pwdata[11:0];
        nsp_pkg::OFS_MEM_DATA:
        begin
          // ignored while an instruction owns the write port
          if (ph_r == nsp_pkg::NSP_IDLE)
          begin
            mem_we = 1'b1;
          end
        end
        default:               pslverr_nxt = 1'b1;
      endcase
    end
    if (rd_en)
    begin
      case (paddr)
        nsp_pkg::OFS_INSTR:    prdata_nxt = {16'h0000, ir_r};
        nsp_pkg::OFS_BANK_SEL: prdata_nxt = {24'h000000, bank_select_reg_r};
        nsp_pkg::OFS_STATUS:   prdata_nxt = {27'h0000000, status_r};
        nsp_pkg::OFS_TOP:
          prdata_nxt = (sp_r == '0) ? 32'h0000_0000 : {11'h000, stk_r[sp_r - 5'd1]};
        nsp_pkg::OFS_MEM_ADDR: prdata_nxt = {20'h00000, maddr_r};
        nsp_pkg::OFS_MEM_DATA: prdata_nxt = {24'h000000, dmem_r[maddr_r]};
        nsp_pkg::OFS_DEPTH:    prdata_nxt = {27'h0000000, sp_r};
        default:               pslverr_nxt = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ir_r              <= 16'h0000;
      bank_select_reg_r <= nsp_pkg::BANK_SEL_RST;
      status_r          <= nsp_pkg::STATUS_RST;
      ea_r              <= 12'h000;
      opnd_r            <= 8'h00;
      maddr_r           <= 12'h000;
      sp_r              <= '0;
      ph_r              <= nsp_pkg::NSP_IDLE;
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      busy              <= 1'b0;
    end
    else
    begin
      ir_r              <= ir_nxt;
      bank_select_reg_r <= bank_select_reg_nxt;
      status_r          <= status_nxt;
      ea_r              <= ea_nxt;
      opnd_r            <= opnd_nxt;
      maddr_r           <= maddr_nxt;
      sp_r              <= sp_nxt;
      ph_r              <= ph_nxt;
      prdata            <= prdata_nxt;
      pready            <= pready_nxt;
      pslverr           <= pslverr_nxt;
      busy              <= (ph_nxt != nsp_pkg::NSP_IDLE);
    end
  end

  // storage without reset: contents undefined until written
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
    begin
      dmem_r[mem_wa] <= mem_wd;
    end
    if (push_we)
    begin
      stk_r[sp_r] <= pwdata[nsp_pkg::PC_W-1:0];
    end
  end

endmodule : nsp_exec

// ---- dv/nsp_exec_chk.sv ----
/* nsp_exec_chk: port assertions on nsp_exec.
 assumes: bound to nsp_exec, single clock. */
`timescale 1ns/1ps
module nsp_exec_chk
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // answered instruction write, then four phases
  sequence s_iw; psel && pwrite && pready && paddr == nsp_pkg::OFS_INSTR; endsequence
  sequence s_run; busy [*4] ##1 !busy; endsequence
  chk_busy_start: assert property (s_iw |-> $rose(busy)) else $error("no busy");
  chk_busy_len: assert property ($rose(busy) |-> s_run) else $error("busy length");
  chk_ready_soon: assert property (psel && penable && !busy |-> ##[0:1] pready)
    else $error("no pready");
  chk_ready_one: assert property (pready |=> !pready) else $error("long pready");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("stray pready");
  chk_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata");
  chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  chk_err_unmap: assert property (pready && paddr > nsp_pkg::OFS_DEPTH |-> pslverr)
    else $error("no pslverr");
endmodule : nsp_exec_chk
////////////////////////////////////////////////////////////////////////////////
bind nsp_exec nsp_exec_chk chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy));

// ---- dv/negate_and_stack_pop_exec_bench.sv ----
/* bench: apb scenarios for nsp_exec.
 assumes: nsp_pkg map, checker bound by its own file. */
`timescale 1ns/1ps
module negate_and_stack_pop_exec_bench;
  localparam logic [7:0] MA = nsp_pkg::OFS_MEM_ADDR;
  localparam logic [7:0] MD = nsp_pkg::OFS_MEM_DATA;
  localparam logic [7:0] TP = nsp_pkg::OFS_TOP;
  localparam logic [7:0] DP = nsp_pkg::OFS_DEPTH;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        e;
  int          fails      = 0;
  int          n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  nsp_exec dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  //////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_compared++;
    if (s !== x)
    begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask : chk
  // a hang counts as a mismatch
  task stop_if(input int i);
    if (i > 20)
    begin
      fails++;
      report_and_stop();
    end
  endtask : stop_if
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i <= 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    stop_if(i);
  endtask : bus
  task rc(input string nm, input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask : rc
  task poke(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, MA, {20'h0, a});
    bus(1'b1, MD, {24'h0, d});
  endtask : poke
  task peek(input string nm, input logic [11:0] a, input logic [7:0] x);
    bus(1'b1, MA, {20'h0, a});
    rc(nm, MD, {24'h0, x});
  endtask : peek
  // busy rises with the write's pready, so polling can start on the first edge after it
  task run(input logic [15:0] op);
    int i;
    bus(1'b1, nsp_pkg::OFS_INSTR, {16'h0, op});
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (busy !== 1'b0 && i <= 20);
    stop_if(i);
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  // operands chosen for carry, digit carry, overflow and zero corners
  task t_neg;
    logic [7:0]  ops [4];
    logic [7:0]  f;
    logic [7:0]  r;
    logic [31:0] fl;
    ops = '{8'h3a, 8'h00, 8'h80, 8'h10};
    foreach (ops[k])
    begin
      f = ops[k];
      r = ~f + 8'h01;
      fl = {27'h0, r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
      poke(12'h040 + 12'(k), f);
      run({nsp_pkg::NEG_OPC, 1'b0, 8'h40 + 8'(k)});
      rc("neg value", MD, {24'h0, r});
      rc("neg flags", nsp_pkg::OFS_STATUS, fl);
    end
  endtask : t_neg
  // same f in three banks, so a wrong bank shows as a hit elsewhere
  task t_bank;
    bus(1'b1, nsp_pkg::OFS_BANK_SEL, 32'h3);
    poke(12'h090, 8'h11);
    poke(12'h390, 8'h33);
    poke(12'hf90, 8'h22);
    run(16'h6c90);
    peek("a0 hit", 12'hf90, 8'hde);
    peek("a0 bank0", 12'h090, 8'h11);
    peek("a0 bsr", 12'h390, 8'h33);
    run(16'h6d90);
    peek("a1 hit", 12'h390, 8'hcd);
    run(16'h6e90);
    peek("other opc", 12'hf90, 8'hde);
  endtask : t_bank
  task t_pop;
    bus(1'b1, nsp_pkg::OFS_PUSH, 32'h0031a2);
    bus(1'b1, nsp_pkg::OFS_PUSH, 32'h014332);
    bus(1'b1, nsp_pkg::OFS_PUSH, 32'h1abcde);
    rc("top3", TP, 32'h1abcde);
    run(nsp_pkg::POP_OPC);
    rc("top2", TP, 32'h014332);
    rc("depth2", DP, 32'h2);
    run(nsp_pkg::POP_OPC);
    rc("top1", TP, 32'h0031a2);
    run(nsp_pkg::POP_OPC);
    rc("depth0", DP, 32'h0);
  endtask : t_pop
  task t_err;
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask : t_err
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_neg();
    t_bank();
    t_pop();
    t_err();
    report_and_stop();
  end
endmodule : negate_and_stack_pop_exec_bench
